//--- rtl/wfc_command_port.sv
// Module: cyclic process image and command interpreter of the weighing instrument
`timescale 1ns/1ps
`default_nettype none

module wfc_command_port #(
   parameter int HEART_CYCLES = wfc_pkg::HEART_CYCLES,
   parameter logic [31:0] PASS_KEY = 32'h5A3C_0F96 // Arbitrary password table key
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic byteOrderSelect,
   input wire logic imageStrobe,
   input wire logic [wfc_pkg::OUT_BYTES*8-1:0] outImage,
   output logic [wfc_pkg::IN_BYTES*8-1:0] inImage,
   input wire wfc_pkg::wfc_weigh_t weigh,
   input wire logic [1:0] digIn,
   input wire logic [2:0] controllerDrivenOutputMode,
   input wire logic [2:0] localOutDrive,
   output logic [2:0] digOut,
   output wfc_pkg::wfc_core_t core
);
   wfc_pkg::wfc_state_t st_r;
   wfc_pkg::wfc_state_t st_nxt;

   // ----------------------------------------------------------------
   // Byte order helpers
   // ----------------------------------------------------------------
   // Image byte 0 sits in the low bits; big-endian puts the MSB there
   function automatic logic [31:0] ord32(input logic [31:0] v, input logic le);
      return le ? v : {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction : ord32

   function automatic logic [15:0] ord16(input logic [15:0] v, input logic le);
      return le ? v : {v[7:0], v[15:8]};
   endfunction : ord16

   function automatic logic [31:0] mag(input logic [31:0] v);
      return v[31] ? 32'(-v) : v;
   endfunction : mag

   // ----------------------------------------------------------------
   // Decoded output image and derived status
   // ----------------------------------------------------------------
   logic [15:0] cmdIn;
   logic [15:0] drvIn;
   logic [31:0] wrxIn;
   logic [15:0] status;
   logic cmdEvent;

   // Field extraction from the controller image
   assign cmdIn = ord16(outImage[wfc_pkg::OUT_CMD*8 +: 16], byteOrderSelect);
   assign drvIn = ord16(outImage[wfc_pkg::OUT_DRV*8 +: 16], byteOrderSelect);
   assign wrxIn = ord32(outImage[wfc_pkg::OUT_WRX*8 +: 32], byteOrderSelect);
   // Only a changed code is an order; repeats need another code, such as zero, in between
   assign cmdEvent = imageStrobe && (cmdIn != st_r.prevCmd);

   // Status word assembly
   always_comb begin
      status = 16'h0000;
      status[0] = weigh.cellError;
      status[1] = weigh.adcFault;
      status[2] = weigh.overMax;
      status[3] = weigh.overFullScale;
      status[wfc_pkg::ST_GROSS_RANGE] = mag(weigh.gross) > wfc_pkg::RANGE_LIMIT;
      status[wfc_pkg::ST_NET_RANGE] = mag(weigh.net) > wfc_pkg::RANGE_LIMIT;
      status[6] = weigh.belowMin;
      status[7] = weigh.gross[31];
      status[8] = weigh.net[31];
      status[9] = weigh.peakNeg;
      status[10] = st_r.core.tareOn;
      status[11] = weigh.stable;
      status[12] = weigh.nearZero;
      status[wfc_pkg::ST_HEART] = st_r.heart;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // One process holds all state so every effect of a code is in one place
   always_comb begin
      logic dup;
      logic [2:0] drive;
      dup = 1'b0;
      drive = 3'b000;
      st_nxt = st_r;
      st_nxt.core.zeroPulse = 1'b0;
      st_nxt.core.savePulse = 1'b0;
      st_nxt.core.calZeroPulse = 1'b0;
      st_nxt.core.presetApplyPulse = 1'b0;
      // Free-running seed source, never zero
      st_nxt.lfsr = {st_r.lfsr[30:0], st_r.lfsr[31] ^ st_r.lfsr[21] ^ st_r.lfsr[1] ^ st_r.lfsr[0]};
      // Heartbeat divider
      if (st_r.hbCnt >= 32'(HEART_CYCLES - 1)) begin
         st_nxt.hbCnt = 32'h0000_0000;
         st_nxt.heart = ~st_r.heart;
      end else begin
         st_nxt.hbCnt = st_r.hbCnt + 32'h0000_0001;
      end
      // Cyclic data is taken each refresh; commands only on change
      if (imageStrobe) begin
         st_nxt.prevCmd = cmdIn;
         st_nxt.drvCmd = drvIn;
         st_nxt.writeX = wrxIn;
      end
      for (int i = 0; i < wfc_pkg::CAL_POINTS; i++) begin
         if (32'(i) < 32'(st_r.core.calCount) && st_r.core.calPoint[i] == st_r.sample) begin
            dup = 1'b1;
         end
      end
      if (cmdEvent) begin
         // Write commands use the exchange word of the same image
         case (cmdIn)
            wfc_pkg::C_TARE_ON: st_nxt.core.tareOn = 1'b1;
            wfc_pkg::C_TARE_OFF: st_nxt.core.tareOn = 1'b0;
            wfc_pkg::C_ZERO: st_nxt.core.zeroPulse = 1'b1;
            wfc_pkg::C_KEY_LOCK: st_nxt.core.keyLock = 1'b1;
            wfc_pkg::C_ALL_UNLOCK: begin
               st_nxt.core.keyLock = 1'b0;
               st_nxt.core.dispLock = 1'b0;
            end
            wfc_pkg::C_ALL_LOCK: begin
               st_nxt.core.keyLock = 1'b1;
               st_nxt.core.dispLock = 1'b1;
            end
            wfc_pkg::C_SAVE: st_nxt.core.savePulse = 1'b1;
            wfc_pkg::C_RD_PTARE: st_nxt.readX = st_r.core.presetTare;
            wfc_pkg::C_WR_PTARE: st_nxt.core.presetTare = wrxIn;
            wfc_pkg::C_PTARE_ON: st_nxt.core.presetApplyPulse = 1'b1;
            wfc_pkg::C_RD_SAMPLE: st_nxt.readX = st_r.sample;
            wfc_pkg::C_WR_SAMPLE: st_nxt.sample = wrxIn;
            wfc_pkg::C_RD_SEED: st_nxt.readX = st_r.seed;
            wfc_pkg::C_RD_ID: st_nxt.readX = st_r.idCode;
            wfc_pkg::C_WR_ID: st_nxt.idCode = wrxIn;
            wfc_pkg::C_SEND_ID: begin
               if (st_r.idCode != 32'h0000_0000) begin
                  st_nxt.seed = st_r.lfsr;
                  st_nxt.idSent = 1'b1;
               end
            end
            wfc_pkg::C_SEND_PASS: begin
               if (st_r.idSent && st_r.idCode == (st_r.seed ^ PASS_KEY)) begin
                  st_nxt.core.access = 1'b1;
                  st_nxt.seed = 32'h0000_0000;
               end
            end
            wfc_pkg::C_CAL_ZERO: begin
               if (st_r.core.access) begin
                  st_nxt.core.calZeroPulse = 1'b1;
               end
            end
            wfc_pkg::C_CAL_FIRST: begin
               if (st_r.core.access && st_r.sample != 32'h0000_0000) begin
                  st_nxt.core.calPoint = '0;
                  st_nxt.core.calPoint[0] = st_r.sample;
                  st_nxt.core.calCount = 4'h1;
                  st_nxt.core.realCal = 1'b1;
                  st_nxt.sample = 32'h0000_0000;
               end
            end
            wfc_pkg::C_CAL_ADD: begin
               if (st_r.core.access && st_r.sample != 32'h0000_0000 && !dup &&
                   st_r.core.calCount < 4'(wfc_pkg::CAL_POINTS)) begin
                  st_nxt.core.calPoint[st_r.core.calCount[2:0]] = st_r.sample;
                  st_nxt.core.calCount = st_r.core.calCount + 4'h1;
                  st_nxt.core.realCal = 1'b1;
                  st_nxt.sample = 32'h0000_0000;
               end
            end
            wfc_pkg::C_CAL_CANCEL: begin
               // Zero-tare adjustment is held elsewhere and stays untouched
               if (st_r.core.access) begin
                  st_nxt.core.realCal = 1'b0;
                  st_nxt.core.calCount = 4'h0;
               end
            end
            default: begin
               // Setpoint ranges; any other code has no effect
               if (cmdIn >= wfc_pkg::C_RD_SP1 && cmdIn <= wfc_pkg::C_RD_SP3) begin
                  st_nxt.readX = st_r.core.setpoint[2'(cmdIn - wfc_pkg::C_RD_SP1)];
               end else if (cmdIn >= wfc_pkg::C_WR_SP1 && cmdIn <= wfc_pkg::C_WR_SP3) begin
                  st_nxt.core.setpoint[2'(cmdIn - wfc_pkg::C_WR_SP1)] = wrxIn;
               end
            end
         endcase
      end
      // Output drive, one cycle behind the registered drive word, two behind the command image
      for (int i = 0; i < 3; i++) begin
         drive[i] = (st_r.drvCmd[wfc_pkg::DRV_FORCE] || controllerDrivenOutputMode[i]) ?
                    st_r.drvCmd[i] : localOutDrive[i];
      end
      st_nxt.digOut = drive;
      // Input image: magnitudes only, signs live in the status word
      st_nxt.image = '0;
      st_nxt.image[wfc_pkg::IN_GROSS*8 +: 32] = ord32(mag(weigh.gross), byteOrderSelect);
      st_nxt.image[wfc_pkg::IN_NET*8 +: 32] = ord32(mag(weigh.net), byteOrderSelect);
      st_nxt.image[wfc_pkg::IN_RDX*8 +: 32] = ord32(st_r.readX, byteOrderSelect);
      st_nxt.image[wfc_pkg::IN_STATUS*8 +: 16] = ord16(status, byteOrderSelect);
      st_nxt.image[wfc_pkg::IN_DIN*8 +: 16] = ord16({14'h0000, digIn}, byteOrderSelect);
      st_nxt.image[wfc_pkg::IN_DOUT*8 +: 16] = ord16({13'h0000, st_r.digOut}, byteOrderSelect);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Access and setpoints vanish at reset, which stands for power-off
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.lfsr <= 32'h0000_0001;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign inImage = st_r.image;
   assign digOut = st_r.digOut;
   assign core = st_r.core;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_heart_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st_r.hbCnt == 32'(HEART_CYCLES - 1)) |=> (st_r.heart != $past(st_r.heart)))
      else $error("heartbeat missed its toggle");
   a_heart_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st_r.hbCnt != 32'(HEART_CYCLES - 1)) |=> $stable(st_r.heart))
      else $error("heartbeat toggled early");
   a_repeat_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
      (imageStrobe && cmdIn == st_r.prevCmd && cmdIn == wfc_pkg::C_ZERO)
      |=> !st_r.core.zeroPulse)
      else $error("repeated command acted on");
   a_zero_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cmdEvent && cmdIn == wfc_pkg::C_ZERO) |=> st_r.core.zeroPulse ##1 !st_r.core.zeroPulse)
      else $error("zero command pulse wrong");
   a_force_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_r.drvCmd[wfc_pkg::DRV_FORCE] |=> (digOut == $past(st_r.drvCmd[2:0])))
      else $error("forced outputs not following command");
   a_local_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!st_r.drvCmd[wfc_pkg::DRV_FORCE] && controllerDrivenOutputMode == 3'b000)
      |=> (digOut == $past(localOutDrive)))
      else $error("local outputs overridden");
   a_cal_gated: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cmdEvent && !st_r.core.access) |=> $stable(st_r.core.calCount))
      else $error("calibration changed without access");
   a_cal_bound: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_r.core.calCount <= 4'(wfc_pkg::CAL_POINTS))
      else $error("too many calibration points");
   a_sample_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
      (st_r.core.calCount != $past(st_r.core.calCount) && st_r.core.calCount != 4'h0)
      |-> st_r.sample == 32'h0000_0000)
      else $error("sample not cleared after store");
   a_access_seed: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(st_r.core.access) |-> st_r.seed == 32'h0000_0000)
      else $error("seed not zero on granted access");
   // Image was packed with the byte order of the cycle before, so look up bit 15 with that one
   a_status_heart: assert property (@(posedge ref_clk) disable iff (!nrst)
      ##1 st_r.image[wfc_pkg::IN_STATUS*8 + ($past(byteOrderSelect) ? 15 : 7)]
      == $past(st_r.heart))
      else $error("status heartbeat mismatch");
   a_preset_only: assert property (@(posedge ref_clk) disable iff (!nrst)
      st_r.core.presetApplyPulse |-> $past(cmdEvent && cmdIn == wfc_pkg::C_PTARE_ON))
      else $error("preset tare applied without enable");

   c_access: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(st_r.core.access));
   c_cal_full: cover property (@(posedge ref_clk) disable iff (!nrst)
      st_r.core.calCount == 4'(wfc_pkg::CAL_POINTS));
   c_cancel: cover property (@(posedge ref_clk) disable iff (!nrst) $fell(st_r.core.realCal));
   c_save: cover property (@(posedge ref_clk) disable iff (!nrst) st_r.core.savePulse);
endmodule : wfc_command_port

`default_nettype wire

//--- rtl/wfc_pkg.sv
// Package: constants and carrier types of the weighing fieldbus command port
package wfc_pkg;
   // ----------------------------------------------------------------
   // Image layout (byte offsets)
   // ----------------------------------------------------------------
   localparam int IN_BYTES = 18;
   localparam int OUT_BYTES = 8;
   localparam int IN_GROSS = 'h0000;
   localparam int IN_NET = 'h0004;
   localparam int IN_RDX = 'h0008;
   localparam int IN_STATUS = 'h000C;
   localparam int IN_DIN = 'h000E;
   localparam int IN_DOUT = 'h0010;
   localparam int OUT_CMD = 'h0000;
   localparam int OUT_DRV = 'h0002;
   localparam int OUT_WRX = 'h0004;
   // ----------------------------------------------------------------
   // Status and output command bit positions
   // ----------------------------------------------------------------
   localparam int ST_GROSS_RANGE = 4;
   localparam int ST_NET_RANGE = 5;
   localparam int ST_HEART = 15;
   localparam int DRV_FORCE = 15;
   localparam logic [31:0] RANGE_LIMIT = 32'h000F_423F;
   localparam int CAL_POINTS = 8;
   localparam int NUM_SETPOINTS = 3;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int HEART_MS = 1000;
   localparam int HEART_CYCLES = CLK_HZ / 1000 * HEART_MS;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [15:0] C_NONE = 16'h0000;
   localparam logic [15:0] C_TARE_ON = 16'h0007;
   localparam logic [15:0] C_ZERO = 16'h0008;
   localparam logic [15:0] C_TARE_OFF = 16'h0009;
   localparam logic [15:0] C_KEY_LOCK = 16'h0015;
   localparam logic [15:0] C_ALL_UNLOCK = 16'h0016;
   localparam logic [15:0] C_ALL_LOCK = 16'h0017;
   localparam logic [15:0] C_RD_PTARE = 16'h0057;
   localparam logic [15:0] C_WR_PTARE = 16'h0058;
   localparam logic [15:0] C_RD_SP1 = 16'h005A;
   localparam logic [15:0] C_RD_SP3 = 16'h005C;
   localparam logic [15:0] C_WR_SP1 = 16'h005D;
   localparam logic [15:0] C_WR_SP3 = 16'h005F;
   localparam logic [15:0] C_SAVE = 16'h0063;
   localparam logic [15:0] C_CAL_ZERO = 16'h0064;
   localparam logic [15:0] C_CAL_FIRST = 16'h0065;
   localparam logic [15:0] C_RD_SAMPLE = 16'h0066;
   localparam logic [15:0] C_WR_SAMPLE = 16'h0067;
   localparam logic [15:0] C_CAL_CANCEL = 16'h0068;
   localparam logic [15:0] C_CAL_ADD = 16'h006A;
   localparam logic [15:0] C_SEND_ID = 16'h0078;
   localparam logic [15:0] C_SEND_PASS = 16'h0079;
   localparam logic [15:0] C_RD_SEED = 16'h007A;
   localparam logic [15:0] C_RD_ID = 16'h007B;
   localparam logic [15:0] C_WR_ID = 16'h007C;
   localparam logic [15:0] C_PTARE_ON = 16'h0082;
   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] gross;
      logic [31:0] net;
      logic peakNeg;
      logic cellError;
      logic adcFault;
      logic overMax;
      logic overFullScale;
      logic belowMin;
      logic stable;
      logic nearZero;
   } wfc_weigh_t;
   typedef struct packed {
      logic zeroPulse;
      logic savePulse;
      logic calZeroPulse;
      logic presetApplyPulse;
      logic tareOn;
      logic keyLock;
      logic dispLock;
      logic access;
      logic realCal;
      logic [3:0] calCount;
      logic [31:0] presetTare;
      logic [NUM_SETPOINTS-1:0][31:0] setpoint;
      logic [CAL_POINTS-1:0][31:0] calPoint;
   } wfc_core_t;
   typedef struct packed {
      logic [15:0] prevCmd;
      logic [15:0] drvCmd;
      logic [31:0] writeX;
      logic [31:0] readX;
      logic [31:0] sample;
      logic [31:0] idCode;
      logic [31:0] seed;
      logic [31:0] lfsr;
      logic idSent;
      logic [31:0] hbCnt;
      logic heart;
      logic [2:0] digOut;
      logic [IN_BYTES*8-1:0] image;
      wfc_core_t core;
   } wfc_state_t;
endpackage : wfc_pkg

//--- testbench/test_wfc_command_port.sv
// Self-checking testbench of the weighing fieldbus command port
`timescale 1ns/1ps
`default_nettype none
module test_wfc_command_port;
   localparam int HB = 16;
   localparam logic [31:0] KEY = 32'h1234_ABCD; // Arbitrary password table key
   logic ref_clk, nrst, byteOrderSelect, imageStrobe;
   logic [63:0] outImage;
   logic [143:0] inImage;
   wfc_pkg::wfc_weigh_t weigh;
   wfc_pkg::wfc_core_t core, snap;
   logic [1:0] digIn;
   logic [2:0] ctlMode, localDrv, digOut;
   logic [15:0] drv, s16;
   logic [31:0] seed;
   int n_mismatch, tests_run, nZero, nSave, nCal, nPre;
   logic [15:0] lvlCode [5] = '{16'h0007, 16'h0009, 16'h0015, 16'h0016, 16'h0017};
   logic [2:0] lvlExp [5] = '{3'h4, 3'h0, 3'h2, 3'h0, 3'h3};
   logic [15:0] drvVal [4] = '{16'h0000, 16'h0007, 16'h8000, 16'h8005};
   logic [2:0] drvExp [4] = '{3'h6, 3'h7, 3'h0, 3'h5};
   wfc_command_port #(.HEART_CYCLES(HB), .PASS_KEY(KEY)) i_dut (
      .ref_clk(ref_clk), .nrst(nrst), .byteOrderSelect(byteOrderSelect),
      .imageStrobe(imageStrobe), .outImage(outImage), .inImage(inImage), .weigh(weigh),
      .digIn(digIn), .controllerDrivenOutputMode(ctlMode), .localOutDrive(localDrv),
      .digOut(digOut), .core(core));
   wfc_plc_model i_plc (.ref_clk(ref_clk), .byteOrderSelect(byteOrderSelect),
      .inImage(inImage), .imageStrobe(imageStrobe), .outImage(outImage));
   // ----------------------------------------------------------------
   // Clock, pulse tallies, helpers
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Pulses last one cycle, so tallies catch doubles that a level check would miss
   always @(posedge ref_clk) begin
      if (core.zeroPulse === 1'b1) nZero++;
      if (core.savePulse === 1'b1) nSave++;
      if (core.calZeroPulse === 1'b1) nCal++;
      if (core.presetApplyPulse === 1'b1) nPre++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic tx(input logic [15:0] c, input logic [31:0] w);
      i_plc.send(c, drv, w);
   endtask : tx
   task automatic rdx(input logic [15:0] c, input logic [31:0] exp, input string msg);
      tx(c, 32'h0000_0000);
      check(i_plc.rd32(wfc_pkg::IN_RDX), exp, msg);
   endtask : rdx
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   // Watchdog sized far above the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      $display("watchdog expired");
      summarize();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      byteOrderSelect = 1'b0;
      weigh = '0;
      digIn = 2'h0;
      ctlMode = 3'h0;
      localDrv = 3'h0;
      drv = 16'h0000;
      repeat (6) @(negedge ref_clk);
      check(32'(core === '0), 32'h0000_0001, "core in reset");
      check({29'h0, digOut}, 32'h0000_0000, "outputs in reset");
      nrst = 1'b1;
      // Weights as magnitudes, signs and alarms in status, both byte orders
      weigh = '{gross:32'hFFFF_FFFB, net:32'h000F_4240, peakNeg:1, cellError:1, adcFault:0,
         overMax:1, overFullScale:0, belowMin:1, stable:1, nearZero:0};
      digIn = 2'h2;
      for (int le = 0; le < 2; le++) begin
         byteOrderSelect = le[0];
         // Second pass flips every flag so each weight-driven status bit is seen both ways
         if (le == 1) begin
            weigh = '{gross:32'h000F_4240, net:32'hFFFF_FFFB, peakNeg:0, cellError:0, adcFault:1,
               overMax:0, overFullScale:1, belowMin:0, stable:0, nearZero:1};
            digIn = 2'h1;
         end
         repeat (3) @(negedge ref_clk);
         check(i_plc.rd32(wfc_pkg::IN_GROSS), le ? 32'h000F_4240 : 32'h5, "gross");
         check(i_plc.rd32(wfc_pkg::IN_NET), le ? 32'h5 : 32'h000F_4240, "net");
         s16 = i_plc.rd16(wfc_pkg::IN_STATUS);
         check({17'h0, s16[14:0]}, le ? 32'h0000_111A : 32'h0000_0AE5, "status");
         check({16'h0, i_plc.rd16(wfc_pkg::IN_DIN)}, le ? 32'h1 : 32'h2, "inputs");
      end
      repeat (HB) @(negedge ref_clk);
      check(32'(i_plc.rd16(wfc_pkg::IN_STATUS) >> 15), {31'h0, ~s16[15]}, "beat");
      $display("image test done");
      // Level commands, net display mode follows tare
      for (int i = 0; i < 5; i++) begin
         tx(lvlCode[i], 32'h0000_0000);
         check({29'h0, core.tareOn, core.keyLock, core.dispLock}, {29'h0, lvlExp[i]}, "lvl");
         s16 = i_plc.rd16(wfc_pkg::IN_STATUS);
         check({31'h0, s16[10]}, {31'h0, lvlExp[i][2]}, "net mode");
      end
      // Repeat needs another code, such as zero, in between; unknown code leaves state alone
      tx(16'h0008, 0);
      tx(16'h0008, 0);
      tx(16'h0000, 0);
      tx(16'h0008, 0);
      tx(16'h0063, 0);
      check(nZero, 2, "zero count");
      check(nSave, 1, "save count");
      snap = core;
      tx(16'h0001, 32'hFFFF_FFFF);
      check(32'(core === snap), 32'h0000_0001, "unknown code");
      $display("command test done");
      // Setpoints and preset tare through the exchange words
      for (int i = 0; i < 3; i++) tx(wfc_pkg::C_WR_SP1 + 16'(i), 32'h0001_0000 + i);
      for (int i = 0; i < 3; i++) begin
         rdx(wfc_pkg::C_RD_SP1 + 16'(i), 32'h0001_0000 + i, "setpoint");
         check(core.setpoint[i], 32'h0001_0000 + i, "setpoint reg");
      end
      tx(wfc_pkg::C_WR_SP3, 32'h0000_0BAD);
      check(i_plc.rd32(wfc_pkg::IN_RDX), 32'h0001_0002, "read word kept");
      tx(wfc_pkg::C_WR_PTARE, 32'h0000_0123);
      check(nPre, 0, "preset early");
      rdx(wfc_pkg::C_RD_PTARE, 32'h0000_0123, "preset tare");
      tx(wfc_pkg::C_PTARE_ON, 0);
      check(nPre, 1, "preset apply");
      // Calibration refused before qualified access
      tx(wfc_pkg::C_CAL_ZERO, 0);
      tx(wfc_pkg::C_WR_SAMPLE, 32'h0000_0005);
      tx(wfc_pkg::C_CAL_FIRST, 0);
      check({27'h0, nCal[0], core.calCount}, 32'h0000_0000, "no access");
      // Seed and password, wrong one first
      tx(wfc_pkg::C_WR_ID, 32'h0000_0042);
      tx(wfc_pkg::C_SEND_ID, 0);
      tx(wfc_pkg::C_RD_SEED, 0);
      seed = i_plc.rd32(wfc_pkg::IN_RDX);
      tx(wfc_pkg::C_WR_ID, seed);
      tx(wfc_pkg::C_SEND_PASS, 0);
      check({31'h0, core.access}, 32'h0000_0000, "bad password");
      tx(wfc_pkg::C_WR_ID, seed ^ KEY);
      tx(wfc_pkg::C_SEND_PASS, 0);
      rdx(wfc_pkg::C_RD_SEED, 32'h0000_0000, "seed cleared");
      check({31'h0, core.access}, 32'h0000_0001, "access");
      rdx(wfc_pkg::C_RD_ID, seed ^ KEY, "id read");
      $display("access test done");
      // Calibration: signed first point, refusals, eight point ceiling, restart, cancel
      tx(wfc_pkg::C_CAL_ZERO, 0);
      check(nCal, 1, "cal zero");
      tx(wfc_pkg::C_WR_SAMPLE, 32'hFFFF_FFC8);
      tx(wfc_pkg::C_CAL_FIRST, 0);
      check(core.calPoint[0], 32'hFFFF_FFC8, "first point");
      rdx(wfc_pkg::C_RD_SAMPLE, 32'h0000_0000, "sample cleared");
      for (int k = 0; k < 10; k++) begin
         tx(wfc_pkg::C_WR_SAMPLE, k == 0 ? 32'hFFFF_FFC8 : 32'(k - 1));
         tx(wfc_pkg::C_CAL_ADD, 0);
      end
      check({27'h0, core.realCal, core.calCount}, 32'h0000_0018, "eight points");
      check(core.calPoint[7], 32'h0000_0007, "last point");
      tx(wfc_pkg::C_WR_SAMPLE, 32'h0000_0032);
      tx(wfc_pkg::C_CAL_FIRST, 0);
      check({core.calPoint[0][27:0], core.calCount}, 32'h0000_0321, "restart");
      tx(wfc_pkg::C_CAL_CANCEL, 0);
      check({27'h0, core.realCal, core.calCount}, 32'h0000_0000, "cancel");
      check(nCal, 1, "zero kept");
      $display("calibration test done");
      // Output drive: one controller-driven output, force bit takes all
      ctlMode = 3'h1;
      localDrv = 3'h6;
      for (int i = 0; i < 4; i++) begin
         drv = drvVal[i];
         tx(16'h0000, 0);
         check({29'h0, digOut}, {29'h0, drvExp[i]}, "outputs");
         check({16'h0, i_plc.rd16(wfc_pkg::IN_DOUT)}, {29'h0, drvExp[i]}, "out word");
      end
      $display("output test done");
      summarize();
   end
endmodule : test_wfc_command_port
`default_nettype wire

//--- testbench/wfc_plc_model.sv
// Fieldbus controller model exchanging cyclic images with the command port
`timescale 1ns/1ps
`default_nettype none
module wfc_plc_model #(
   parameter int REFRESH_CYCLES = 3 // Scaled down from the controller's 8 ms floor
) (
   input wire logic ref_clk,
   input wire logic byteOrderSelect,
   input wire logic [wfc_pkg::IN_BYTES*8-1:0] inImage,
   output logic imageStrobe,
   output logic [wfc_pkg::OUT_BYTES*8-1:0] outImage
);
   // ----------------------------------------------------------------
   // Byte order helpers
   // ----------------------------------------------------------------
   // Big-endian puts the top byte at the lowest offset; the swap is its own inverse
   function automatic logic [31:0] ord32(input logic [31:0] v);
      return byteOrderSelect ? v : {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction : ord32
   function automatic logic [15:0] ord16(input logic [15:0] v);
      return byteOrderSelect ? v : {v[7:0], v[15:8]};
   endfunction : ord16
   function automatic logic [31:0] rd32(input int ofs);
      return ord32(inImage[8*ofs +: 32]);
   endfunction : rd32
   function automatic logic [15:0] rd16(input int ofs);
      return ord16(inImage[8*ofs +: 16]);
   endfunction : rd16
   // ----------------------------------------------------------------
   // Image exchange
   // ----------------------------------------------------------------
   // Quiet bus at time zero
   initial begin
      imageStrobe = 1'b0;
      outImage = '0;
   end
   // Datum and command travel in one image, so a write always carries its value
   task automatic send(input logic [15:0] cmd, input logic [15:0] drv, input logic [31:0] wrx);
      @(negedge ref_clk);
      outImage <= {ord32(wrx), ord16(drv), ord16(cmd)};
      imageStrobe <= 1'b1;
      @(negedge ref_clk);
      imageStrobe <= 1'b0;
      outImage <= ~outImage; // Released image must not look valid
      repeat (REFRESH_CYCLES) @(negedge ref_clk);
   endtask : send
endmodule : wfc_plc_model
`default_nettype wire
